// ==== dit_timer.sv ====
// Dual 16-bit interval timer with interrupt flags, reached over the register select bus
//
// Functional notes
// R01 - Timer one: two 8-bit reload latches and a 16-bit counter decrementing each clock.
// R02 - Auxiliary control bits 6 and 7 pick one of four timer one modes.
// R03 - Reading register 4 gives counter low byte, clears flag; writing loads low latch.
// R04 - Writing register 5 loads high latch, copies latches to counter, starts, clears flag.
// R05 - Reading register 6 gives low latch, flag untouched; writes act like register 4.
// R06 - Register 7 reads and writes the high latch only, no counter transfer.
// R07 - One-shot mode flags once at zero per high-byte write, then stays quiet.
// R08 - One-shot with pin enabled: pin low after high write, high at zero.
// R09 - Free-run: each time-out sets flag, toggles pin, reloads 16 bits, keeps counting.
// R10 - Latch-only writes leave the running count alone; they shape the next period.
// R11 - Pin shows timer wave only if direction bit 7 and control bit 7 set.
// R12 - One control bit picks timer two interval or pulse counting mode.
// R13 - Timer two: write-only low latch, read-only low count, read/write high count.
// R14 - Timer two one-shot wraps to FFFF after time-out and keeps counting.
// R15 - Timer two flags only once until the high count byte is rewritten.
// R16 - Register 8 write loads timer two latch; read gives low count, clears flag.
// R17 - Register 9 write loads high count, copies latch low, clears flag.
// R18 - Pulse mode counts falling pulses on input pin, flags at zero, keeps counting.
// R19 - Pulse mode flags again only after the high count byte is rewritten.
// R20 - The source holds each counted pulse low across a sampling clock edge.
// R21 - Interrupt request pin pulled low while any flag meets its enable bit.
// R22 - Flag register bit 7 reads 1 while any enabled interrupt is active.
// R23 - Four select lines decode sixteen registers at the documented numbers; the code decodes eleven of them, the other five read zero.
// R24 - Auxiliary control bit 5 selects pulse counting when 1, interval when 0.
`include "dit_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module dit_timer (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire dit_pkg::dit_bus_req_t bus_req,
  output logic [7:0]                 data_out,
  output logic                       data_oe,
  output logic                       irq_n_out,
  output logic                       irq_n_oe,
  output logic                       timer_one_output_pin_out,
  output logic                       timer_one_output_pin_oe,
  input  wire logic                  pulse_count_input_pin
);

  dit_pkg::dit_state_t st;
  dit_pkg::dit_state_t next_st;

  // Zero test shared by both timers
  function automatic logic is_zero(input logic [15:0] v);
    is_zero = (v == 16'h0000);
  endfunction

  logic wr;
  logic rd;
  logic t1_hi_wr;
  logic t2_hi_wr;
  logic t1_to;
  logic t1_set;
  logic t1_clr;
  logic t2_to;
  logic t2_dec;
  logic t2_clr;
  logic pc_stable;
  logic pc_fall;
  logic irq_any;
  logic [7:0] rbyte;

  // Access decode
  assign wr       = bus_req.strobe & ~bus_req.read;
  assign rd       = bus_req.strobe & bus_req.read;
  assign t1_hi_wr = wr & (bus_req.sel == `DIT_REG_T1_CNT_HI);
  assign t2_hi_wr = wr & (bus_req.sel == `DIT_REG_T2_CNT_HI);

  // Pulse input filter: a new level counts once second and third stages agree
  assign pc_stable = (st.pc_sync[1] == st.pc_sync[2]);
  assign pc_fall   = st.pc_level & pc_stable & ~st.pc_sync[2]; // [R20]

  // Interrupt combine, only the two timer flags exist here
  assign irq_any = (st.t1_flag & st.interrupt_enable_register[`DIT_IFR_T1])
                 | (st.t2_flag & st.interrupt_enable_register[`DIT_IFR_T2]);

  // Timer one time-out and flag terms
  assign t1_to  = is_zero(st.t1_cnt);
  assign t1_set = t1_to & (st.auxiliary_control[`DIT_ACR_T1_FREE_RUN] | st.t1_armed); // [R07] [R09]
  assign t1_clr = (rd & (bus_req.sel == `DIT_REG_T1_CNT_LO)) // [R03]
                | (wr & (bus_req.sel == `DIT_REG_IRQ_FLAG) & bus_req.wdata[`DIT_IFR_T1]);

  // Timer two counts clocks or filtered falling pulses
  assign t2_dec = st.auxiliary_control[`DIT_ACR_T2_PULSE] ? pc_fall : 1'b1; // [R12] [R24] [R18]
  assign t2_to  = is_zero(st.t2_cnt) & st.t2_armed; // [R15] [R19]
  assign t2_clr = (rd & (bus_req.sel == `DIT_REG_T2_CNT_LO)) // [R16]
                | (wr & (bus_req.sel == `DIT_REG_IRQ_FLAG) & bus_req.wdata[`DIT_IFR_T2]);

  // Read data selection
  always_comb begin
    case (bus_req.sel) // [R23]
      `DIT_REG_PORT_B_OUT:  rbyte = st.port_b_output_register;
      `DIT_REG_PORT_B_DIR:  rbyte = st.port_b_direction;
      `DIT_REG_T1_CNT_LO:   rbyte = st.t1_cnt[7:0];  // [R03]
      `DIT_REG_T1_CNT_HI:   rbyte = st.t1_cnt[15:8]; // [R04]
      `DIT_REG_T1_LAT_LO:   rbyte = st.t1_lat_lo;    // [R05]
      `DIT_REG_T1_LAT_HI:   rbyte = st.t1_lat_hi;    // [R06]
      `DIT_REG_T2_CNT_LO:   rbyte = st.t2_cnt[7:0];  // [R13]
      `DIT_REG_T2_CNT_HI:   rbyte = st.t2_cnt[15:8]; // [R13]
      `DIT_REG_AUX_CTRL:    rbyte = st.auxiliary_control;
      `DIT_REG_IRQ_FLAG: begin
        rbyte = 8'h00;
        rbyte[`DIT_IFR_ANY] = irq_any; // [R22]
        rbyte[`DIT_IFR_T1]  = st.t1_flag;
        rbyte[`DIT_IFR_T2]  = st.t2_flag;
      end
      `DIT_REG_IRQ_ENABLE:  rbyte = {1'b1, st.interrupt_enable_register};
      default:              rbyte = 8'h00;
    endcase
  end

  // Next state
  always_comb begin
    next_st = st;

    // Three-stage synchroniser, first stage feeds only the second
    next_st.pc_sync = {st.pc_sync[1:0], pulse_count_input_pin};
    if (pc_stable) begin
      next_st.pc_level = st.pc_sync[2];
    end

    // Timer one latches; latch-only writes leave the count running
    if (wr && (bus_req.sel == `DIT_REG_T1_CNT_LO || bus_req.sel == `DIT_REG_T1_LAT_LO)) begin
      next_st.t1_lat_lo = bus_req.wdata; // [R03] [R05] [R10]
    end
    if (wr && (bus_req.sel == `DIT_REG_T1_LAT_HI)) begin
      next_st.t1_lat_hi = bus_req.wdata; // [R06] [R10]
    end

    // Timer one counter
    if (t1_hi_wr) begin
      next_st.t1_lat_hi = bus_req.wdata;                  // [R04]
      next_st.t1_cnt    = {bus_req.wdata, st.t1_lat_lo};  // [R04]
      next_st.t1_armed  = 1'b1;
      next_st.t1_wave   = 1'b0;                           // [R08]
    end else if (t1_to && st.auxiliary_control[`DIT_ACR_T1_FREE_RUN]) begin
      next_st.t1_cnt  = {st.t1_lat_hi, st.t1_lat_lo};     // [R09] [R02]
      next_st.t1_wave = ~st.t1_wave;                      // [R09]
    end else begin
      next_st.t1_cnt = st.t1_cnt - 16'h0001;              // [R01]
      if (t1_to && st.t1_armed) begin
        next_st.t1_armed = 1'b0;                          // [R07]
        next_st.t1_wave  = 1'b1;                          // [R08]
      end
    end

    // Timer one flag: a restart clears it, otherwise a set beats a clear
    if (t1_hi_wr) begin
      next_st.t1_flag = 1'b0; // [R04]
    end else begin
      next_st.t1_flag = (st.t1_flag & ~t1_clr) | t1_set;
    end

    // Timer two latch and counter
    if (wr && (bus_req.sel == `DIT_REG_T2_CNT_LO)) begin
      next_st.t2_lat_lo = bus_req.wdata; // [R16]
    end
    if (t2_hi_wr) begin
      next_st.t2_cnt   = {bus_req.wdata, st.t2_lat_lo}; // [R17]
      next_st.t2_armed = 1'b1;                          // [R15] [R19]
      next_st.t2_flag  = 1'b0;                          // [R17]
    end else begin
      if (t2_dec) begin
        next_st.t2_cnt = st.t2_cnt - 16'h0001; // Wraps past zero [R14] [R13]
      end
      if (t2_to) begin
        next_st.t2_armed = 1'b0;
      end
      next_st.t2_flag = (st.t2_flag & ~t2_clr) | t2_to; // [R18]
    end

    // Control registers
    if (wr) begin
      case (bus_req.sel)
        `DIT_REG_PORT_B_OUT: next_st.port_b_output_register  = bus_req.wdata;
        `DIT_REG_PORT_B_DIR: next_st.port_b_direction = bus_req.wdata;
        `DIT_REG_AUX_CTRL:   next_st.auxiliary_control  = bus_req.wdata; // [R02] [R12]
        `DIT_REG_IRQ_ENABLE: begin
          if (bus_req.wdata[`DIT_IER_SET_CLR]) begin
            next_st.interrupt_enable_register = st.interrupt_enable_register | bus_req.wdata[6:0];
          end else begin
            next_st.interrupt_enable_register = st.interrupt_enable_register & ~bus_req.wdata[6:0];
          end
        end
        default: next_st.interrupt_enable_register = st.interrupt_enable_register;
      endcase
    end

    // Read data held until the next read
    if (rd) begin
      next_st.rdata = rbyte;
    end
    next_st.rd_oe = rd;
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st.t1_lat_lo <= `DIT_RST_BYTE;
      st.t1_lat_hi <= `DIT_RST_BYTE;
      st.t1_cnt    <= `DIT_RST_WORD;
      st.t1_armed  <= 1'b0;
      st.t1_wave   <= 1'b1;
      st.t1_flag   <= 1'b0;
      st.t2_lat_lo <= `DIT_RST_BYTE;
      st.t2_cnt    <= `DIT_RST_WORD;
      st.t2_armed  <= 1'b0;
      st.t2_flag   <= 1'b0;
      st.auxiliary_control       <= `DIT_RST_BYTE;
      st.port_b_output_register       <= `DIT_RST_BYTE;
      st.port_b_direction      <= `DIT_RST_BYTE;
      st.interrupt_enable_register       <= `DIT_RST_ENABLE;
      st.pc_sync   <= `DIT_RST_SYNC;
      st.pc_level  <= 1'b1;
      st.rdata     <= `DIT_RST_BYTE;
      st.rd_oe     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Pins; the request line is open drain, only ever driven low
  assign data_out  = st.rdata;
  assign data_oe   = st.rd_oe;
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = irq_any; // [R21]

  // Timer wave reaches the pin only when both enables are set
  assign timer_one_output_pin_out =
    (st.port_b_direction[`DIT_PB_TIMER_BIT] & st.auxiliary_control[`DIT_ACR_T1_PIN_EN]) ? st.t1_wave // [R11]
                                                              : st.port_b_output_register[`DIT_PB_TIMER_BIT];
  assign timer_one_output_pin_oe = st.port_b_direction[`DIT_PB_TIMER_BIT];

endmodule

`default_nettype wire

// ==== dit_consts.svh ====
// Register offsets, field positions and reset values of the dual interval timer
`ifndef DIT_CONSTS_SVH
`define DIT_CONSTS_SVH

// Register select codes
`define DIT_REG_PORT_B_OUT   4'h0
`define DIT_REG_PORT_B_DIR   4'h2
`define DIT_REG_T1_CNT_LO    4'h4
`define DIT_REG_T1_CNT_HI    4'h5
`define DIT_REG_T1_LAT_LO    4'h6
`define DIT_REG_T1_LAT_HI    4'h7
`define DIT_REG_T2_CNT_LO    4'h8
`define DIT_REG_T2_CNT_HI    4'h9
`define DIT_REG_AUX_CTRL     4'hb
`define DIT_REG_IRQ_FLAG     4'hd
`define DIT_REG_IRQ_ENABLE   4'he

// Auxiliary control field positions
`define DIT_ACR_T1_FREE_RUN  6
`define DIT_ACR_T1_PIN_EN    7
`define DIT_ACR_T2_PULSE     5

// Interrupt flag and enable bit positions, and the port B timer pin bit
`define DIT_IFR_T1           6
`define DIT_IFR_T2           5
`define DIT_IFR_ANY          7
`define DIT_IER_SET_CLR      7
`define DIT_PB_TIMER_BIT     7

// Reset values
`define DIT_RST_BYTE         8'h00
`define DIT_RST_WORD         16'h0000
`define DIT_RST_ENABLE       7'h00
`define DIT_RST_SYNC         3'h7

`endif

// ==== dit_pkg.sv ====
// Types shared by the dual interval timer and its environment
package dit_pkg;

  // One register access, valid for the single cycle that strobe is high
  typedef struct packed {
    logic       strobe;
    logic       read;
    logic [3:0] sel;
    logic [7:0] wdata;
  } dit_bus_req_t;

  // Whole state of the timer block
  typedef struct packed {
    logic [7:0]  t1_lat_lo;
    logic [7:0]  t1_lat_hi;
    logic [15:0] t1_cnt;
    logic        t1_armed;
    logic        t1_wave;
    logic        t1_flag;
    logic [7:0]  t2_lat_lo;
    logic [15:0] t2_cnt;
    logic        t2_armed;
    logic        t2_flag;
    logic [7:0]  auxiliary_control;
    logic [7:0]  port_b_output_register;
    logic [7:0]  port_b_direction;
    logic [6:0]  interrupt_enable_register;
    logic [2:0]  pc_sync;
    logic        pc_level;
    logic [7:0]  rdata;
    logic        rd_oe;
  } dit_state_t;

endpackage

// ==== dit_timer_chk.sv ====
// Checker of bus, pin and interrupt relations of the timer block
`timescale 1ns/100ps
`default_nettype none
module dit_timer_chk (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire dit_pkg::dit_bus_req_t bus_req,
  input wire logic [7:0]            data_out,
  input wire logic                  data_oe,
  input wire logic                  irq_n_out,
  input wire logic                  irq_n_oe,
  input wire logic                  timer_one_output_pin_out,
  input wire logic                  timer_one_output_pin_oe,
  input wire logic                  pulse_count_input_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic acr7;
  wire  rd = bus_req.strobe && bus_req.read;
  wire  wr = bus_req.strobe && !bus_req.read;
  // Shadow of the pin control bit: tells who owns the pin level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) acr7 <= 1'b0;
    else if (wr && bus_req.sel == 4'hb) acr7 <= bus_req.wdata[7];
  end
  sequence s_rd(s); rd && bus_req.sel == s; endsequence
  sequence s_wr(s); wr && bus_req.sel == s; endsequence
  a_read_answer: assert property (rd |=> data_oe)
    else $error("read not answered");
  a_idle_quiet: assert property (!rd |=> !data_oe)
    else $error("bus driven without read");
  a_unmapped_zero: assert property (s_rd(4'ha) |=> data_out == 8'h00)
    else $error("unmapped read not zero");
  a_poll_bit7: assert property (s_rd(4'hd) |=> data_out[7] == $past(irq_n_oe))
    else $error("poll bit wrong");
  a_irq_masked: assert property (s_wr(4'he) ##0 bus_req.wdata == 8'h7f |=> !irq_n_oe)
    else $error("request with all enables off");
  a_pin_dir: assert property (s_wr(4'h2) |=> timer_one_output_pin_oe == $past(bus_req.wdata[7]))
    else $error("pin direction wrong");
  a_pin_orb: assert property (s_wr(4'h0) ##0 !acr7
    |=> timer_one_output_pin_out == $past(bus_req.wdata[7]))
    else $error("pin not following output bit");
  a_wave_start: assert property (s_wr(4'h5) ##0 (acr7 && timer_one_output_pin_oe)
    |=> !timer_one_output_pin_out)
    else $error("pin not low after start");
endmodule
bind dit_timer dit_timer_chk i_dit_timer_chk (
  .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .data_out(data_out),
  .data_oe(data_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
  .timer_one_output_pin_out(timer_one_output_pin_out),
  .timer_one_output_pin_oe(timer_one_output_pin_oe),
  .pulse_count_input_pin(pulse_count_input_pin));
`default_nettype wire

// ==== dit_pulse_src.sv ====
// Pulse source feeding the timer two count input
`timescale 1ns/100ps
`default_nettype none
module dit_pulse_src (
  input  wire logic sys_clk,
  output var logic  pin
);
  initial pin = 1'b1;
  // Low over three edges, so the synchroniser cannot miss it
  task automatic pulse();
    @(posedge sys_clk) pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== test_dual_interval_timer.sv ====
// Self-checking bench of the dual interval timer
`timescale 1ns/100ps
`default_nettype none
module test_dual_interval_timer;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  dit_pkg::dit_bus_req_t bus_req = '0;
  logic [7:0]            data_out;
  logic                  data_oe;
  logic                  irq_n_out;
  logic                  irq_n_oe;
  logic                  pin_out;
  logic                  pin_oe;
  logic                  pc_pin;
  logic [7:0]            d;
  int                    n;
  int                    error_cnt = 0;
  int                    checks_done = 0;
  always #25 sys_clk = ~sys_clk;
  dit_timer i_dit_timer (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .data_out(data_out), .data_oe(data_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .timer_one_output_pin_out(pin_out), .timer_one_output_pin_oe(pin_oe),
    .pulse_count_input_pin(pc_pin));
  dit_pulse_src i_dit_pulse_src (.sys_clk(sys_clk), .pin(pc_pin));
  task automatic chk(input logic [15:0] v, input logic [15:0] e);
    checks_done++;
    if (v !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, v, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One-cycle strobe; settled outputs looked at 1 ns past the edge
  task automatic acc(input logic r, input logic [3:0] s, input logic [7:0] v);
    @(posedge sys_clk) bus_req <= {1'b1, r, s, v};
    @(posedge sys_clk) bus_req.strobe <= 1'b0;
    #1 d = data_out;
    if (r) chk(data_oe, 1'b1);
  endtask
  // Bounded wait on the request line, or on a pin change when t is set
  task automatic wt(input logic t);
    logic p;
    p = pin_out;
    n = 0;
    while (t ? pin_out === p : irq_n_oe !== 1'b1) begin
      @(posedge sys_clk) #1 n++;
      if (n > 500) begin
        error_cnt++;
        test_done();
      end
    end
  endtask
  task automatic t1_one_shot();
    acc(0, 4'h2, 8'h80);
    acc(0, 4'hb, 8'h80);
    acc(0, 4'he, 8'hc0);
    acc(0, 4'h4, 8'h05);
    acc(0, 4'h5, 8'h00);
    chk(pin_out, 1'b0);
    wt(0);
    chk({n[7:0], pin_out}, {8'h06, 1'b1});
    acc(1, 4'h4, 8'h00);
    chk(irq_n_oe, 1'b0);
    repeat (40) @(posedge sys_clk);
    chk(irq_n_oe, 1'b0);
  endtask
  // Latch write mid-period must only shape the period after
  task automatic t1_free_run();
    acc(0, 4'hb, 8'hc0);
    acc(0, 4'h6, 8'h03);
    acc(0, 4'h7, 8'h00);
    acc(0, 4'h5, 8'h00);
    wt(1);
    wt(1);
    chk(n, 4);
    acc(0, 4'h6, 8'h07);
    wt(1);
    chk(n, 2);
    wt(1);
    chk(n, 8);
    acc(1, 4'h6, 8'h00);
    chk({irq_n_oe, d}, {1'b1, 8'h07});
    acc(1, 4'h7, 8'h00);
    chk(d, 8'h00);
  endtask
  task automatic t2_interval();
    acc(0, 4'he, 8'h7f);
    acc(0, 4'he, 8'ha0);
    acc(0, 4'hb, 8'h00);
    acc(0, 4'h8, 8'h04);
    acc(0, 4'h9, 8'h00);
    wt(0);
    chk(n, 5);
    acc(1, 4'h9, 8'h00);
    chk(d, 8'hff);
    acc(1, 4'h8, 8'h00);
    chk(irq_n_oe, 1'b0);
  endtask
  // Count held between pulses: an interval timer would have fired
  task automatic t2_pulses();
    acc(0, 4'hb, 8'h20);
    acc(0, 4'h8, 8'h02);
    acc(0, 4'h9, 8'h00);
    i_dit_pulse_src.pulse();
    repeat (8) @(posedge sys_clk);
    chk(irq_n_oe, 1'b0);
    i_dit_pulse_src.pulse();
    wt(0);
    chk(n < 10, 1'b1);
    acc(1, 4'hd, 8'h00);
    chk(d & 8'ha0, 8'ha0);
    acc(1, 4'h8, 8'h00);
    i_dit_pulse_src.pulse();
    repeat (8) @(posedge sys_clk);
    chk(irq_n_oe, 1'b0);
  endtask
  task automatic regs();
    acc(1, 4'he, 8'h00);
    chk(d, 8'ha0);
    acc(1, 4'ha, 8'h00);
    chk(d, 8'h00);
    acc(0, 4'hb, 8'h00);
    acc(0, 4'h0, 8'h80);
    chk({pin_oe, pin_out}, 2'b11);
    acc(0, 4'h0, 8'h00);
    chk(pin_out, 1'b0);
    chk(irq_n_out, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t1_one_shot();
    t1_free_run();
    t2_interval();
    t2_pulses();
    regs();
    test_done();
  end
endmodule
`default_nettype wire
